// ---- rtl/oms_mode_selector.sv ----
// Operation-mode arbiter: parameters, terminal switching, power-on mode
module oms_mode_selector
    import oms_pkg::*;
#(
    parameter int NUM_TERM = 12
)
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       netpanel_switch_input,
    input  wire logic       netext_switch_input,
    input  wire logic       panel_interlock_input,
    input  wire logic       panel_ext_switch_input,
    input  wire logic       motorRunning,
    input  wire logic       startCmd,
    input  wire logic       commOptionFitted,
    input  wire logic       panelKeyToggle,
    input  wire logic       powerFailRestore,
    output oms_mode_t       opMode,
    output logic            output_stop_input
);

    // ----------------------------------------
    // Parameter registers and state
    // ----------------------------------------
    logic [7:0] mode_select_param;
    logic [7:0] startup_mode_param;
    logic [7:0] net_cmd_source_param;
    logic [7:0] write_protect_param;
    logic [7:0] terminal_function_params [NUM_TERM];
    logic       initPending;
    logic [3:0] termSync;
    oms_mode_t  next_opMode;

    logic npIn;
    logic neIn;
    logic lockIn;
    logic peIn;
    assign npIn   = termSync[0];
    assign neIn   = termSync[1];
    assign lockIn = termSync[2];
    assign peIn   = termSync[3];

    // ----------------------------------------
    // Terminal synchronisers
    // ----------------------------------------
    oms_sync #(.WIDTH(4)) u_sync
    (
        .clk     (clk),
        .rst_b   (rst_b),
        .asyncIn ({panel_ext_switch_input, panel_interlock_input,
                   netext_switch_input, netpanel_switch_input}),
        .syncOut (termSync)
    );

    function automatic logic fnAssigned(input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_TERM; i++)
        begin
            if (terminal_function_params[i] == code)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    function automatic logic fnLegalMsel(input logic [7:0] v);
        return (v <= MSEL_COMB_B) || (v == MSEL_SWITCHOVR) || (v == MSEL_INTERLOCK);
    endfunction

    // ----------------------------------------
    // Decoded conditions
    // ----------------------------------------
    logic stopped;
    logic isFixed;
    logic netUnusable;
    logic smodeLow;
    logic smodeHigh;
    logic netExtActive;
    logic netPanelActive;
    logic panelExtActive;
    logic switchOk;

    assign stopped     = !motorRunning || !startCmd;
    assign netUnusable = (net_cmd_source_param == RST_NET_CMD_SRC) && !commOptionFitted;
    assign smodeLow    = startup_mode_param <= SMODE_NET_RST;
    assign smodeHigh   = (startup_mode_param == SMODE_PUNET)
                      || (startup_mode_param == SMODE_PUNET_RST);
    // Priority order is fixed by the order of tests below
    assign isFixed = (mode_select_param == MSEL_PU_FIXED)
                  || (mode_select_param == MSEL_COMB_A)
                  || (mode_select_param == MSEL_COMB_B)
                  || ((mode_select_param == MSEL_INTERLOCK) && !lockIn);
    assign netExtActive = fnAssigned(FN_NETEXT) && smodeLow
                       && ((mode_select_param == RST_MODE_SELECT)
                        || (mode_select_param == MSEL_EXT_NET)
                        || (mode_select_param == MSEL_SWITCHOVR)
                        || (mode_select_param == MSEL_INTERLOCK));
    assign netPanelActive = fnAssigned(FN_NETPANEL) && smodeHigh
                         && ((mode_select_param == RST_MODE_SELECT)
                          || (mode_select_param == MSEL_SWITCHOVR));
    assign panelExtActive = fnAssigned(FN_PANELEXT)
                         && ((mode_select_param == RST_MODE_SELECT)
                          || (mode_select_param == MSEL_SWITCHOVR)
                          || (mode_select_param == MSEL_INTERLOCK));
    // Switching only at stop, except in switch-over setting
    assign switchOk = stopped || (mode_select_param == MSEL_SWITCHOVR);

    // ----------------------------------------
    // Switch-driven target mode
    // ----------------------------------------
    oms_mode_t switchMode;
    logic      switchValid;

    always_comb
    begin
        switchMode  = opMode;
        switchValid = 1'b0;
        if (netExtActive)
        begin
            switchValid = 1'b1;
            if (neIn)
            begin
                switchMode = (netUnusable && (mode_select_param != MSEL_EXT_NET))
                           ? MODE_PU : MODE_NET;
            end
            else if (mode_select_param == MSEL_EXT_NET)
            begin
                switchMode = MODE_EXT;
            end
            else if (netPanelActive)
            begin
                switchMode = npIn ? MODE_PU : MODE_NET;
            end
            else if (panelExtActive)
            begin
                switchMode = peIn ? MODE_EXT : MODE_PU;
            end
            else
            begin
                switchMode = MODE_EXT;
            end
        end
        else if (netPanelActive)
        begin
            switchValid = 1'b1;
            if (npIn)
            begin
                switchMode = neIn ? MODE_NET : MODE_PU;
            end
            else if (netUnusable)
            begin
                switchMode = MODE_PU;
            end
            else if (panelExtActive)
            begin
                switchMode = peIn ? MODE_EXT : MODE_PU;
            end
            else
            begin
                switchMode = MODE_NET;
            end
        end
        else if (panelExtActive)
        begin
            switchValid = 1'b1;
            switchMode  = peIn ? MODE_EXT : MODE_PU;
        end
    end

    // ----------------------------------------
    // Power-on and restoration mode
    // ----------------------------------------
    oms_mode_t startMode;

    always_comb
    begin
        if (mode_select_param == MSEL_PU_FIXED)
        begin
            startMode = MODE_PU;
        end
        else if ((mode_select_param == MSEL_COMB_A) || (mode_select_param == MSEL_COMB_B))
        begin
            startMode = MODE_COMB;
        end
        else if (mode_select_param == MSEL_INTERLOCK)
        begin
            startMode = (lockIn && smodeLow && startup_mode_param != RST_STARTUP_MODE)
                      ? MODE_NET : MODE_EXT;
        end
        else if (startup_mode_param == RST_STARTUP_MODE)
        begin
            startMode = MODE_EXT;
        end
        else
        begin
            startMode = MODE_NET;
        end
    end

    // ----------------------------------------
    // Mode arbitration
    // ----------------------------------------
    logic restoreHeld;
    assign restoreHeld = (startup_mode_param == SMODE_NET_RST)
                      || (startup_mode_param == SMODE_PUNET_RST);

    always_comb
    begin
        next_opMode = opMode;
        case (mode_select_param)
            MSEL_PU_FIXED:  next_opMode = MODE_PU;
            MSEL_COMB_A,
            MSEL_COMB_B:    next_opMode = MODE_COMB;
            default:
            begin
                if ((mode_select_param == MSEL_INTERLOCK) && !lockIn)
                begin
                    next_opMode = MODE_EXT;
                end
                else if (initPending)
                begin
                    next_opMode = startMode;
                end
                else if (powerFailRestore)
                begin
                    next_opMode = restoreHeld ? opMode : startMode;
                end
                else if (switchOk && switchValid)
                begin
                    next_opMode = switchMode;
                end
                else if (switchOk && panelKeyToggle && smodeHigh
                         && (mode_select_param != MSEL_EXT_NET))
                begin
                    // Panel key only toggles between panel and network
                    if (opMode == MODE_PU)
                    begin
                        next_opMode = MODE_NET;
                    end
                    else if (opMode == MODE_NET)
                    begin
                        next_opMode = MODE_PU;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            opMode      <= MODE_EXT;
            initPending <= 1'b1;
        end
        else
        begin
            opMode      <= next_opMode;
            initPending <= 1'b0;
        end
    end

    // Output stop applies only under interlock setting in external mode
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            output_stop_input <= 1'b0;
        end
        else
        begin
            output_stop_input <= (mode_select_param == MSEL_INTERLOCK) && lockIn
                              && (next_opMode == MODE_EXT);
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Interlock off under setting 7 blocks every write but mode select and startup mode
    logic generalWrOk;
    assign generalWrOk = (write_protect_param != WPROT_DISABLED)
                      && !((mode_select_param == MSEL_INTERLOCK) && !lockIn);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mode_select_param <= RST_MODE_SELECT;
        end
        else if (wr && addr == OFS_MODE_SELECT && stopped && fnLegalMsel(wdata))
        begin
            mode_select_param <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            startup_mode_param <= RST_STARTUP_MODE;
        end
        else if (wr && addr == OFS_STARTUP_MODE && (stopped || commOptionFitted)
                 && (write_protect_param != WPROT_DISABLED || stopped))
        begin
            startup_mode_param <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            net_cmd_source_param <= RST_NET_CMD_SRC;
            write_protect_param  <= RST_WRITE_PROT;
        end
        else if (wr && generalWrOk && addr == OFS_NET_CMD_SRC)
        begin
            net_cmd_source_param <= wdata;
        end
        else if (wr && addr == OFS_WRITE_PROT && !((mode_select_param == MSEL_INTERLOCK)
                 && !lockIn))
        begin
            write_protect_param <= wdata;
        end
    end

    // Changing assignments mid-run could jump the mode, so stop is required
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < NUM_TERM; i++)
        begin
            if (!rst_b)
            begin
                terminal_function_params[i] <= RST_TERM_FN;
            end
            else if (wr && generalWrOk && stopped
                     && addr == OFS_TERM_FN_BASE + 8'(4 * i))
            begin
                terminal_function_params[i] <= wdata;
            end
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    logic [7:0] readMux;

    always_comb
    begin
        readMux = 8'h00;
        case (addr)
            OFS_MODE_SELECT:  readMux = mode_select_param;
            OFS_STARTUP_MODE: readMux = startup_mode_param;
            OFS_NET_CMD_SRC:  readMux = net_cmd_source_param;
            OFS_WRITE_PROT:   readMux = write_protect_param;
            OFS_STATUS:       readMux = {3'h0, termSync[2], output_stop_input,
                                         initPending, opMode};
            default:
            begin
                for (int i = 0; i < NUM_TERM; i++)
                begin
                    if (addr == OFS_TERM_FN_BASE + 8'(4 * i))
                    begin
                        readMux = terminal_function_params[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= rd ? readMux : 8'h00;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    fixed_panel_a: assert property (mode_select_param == MSEL_PU_FIXED |=> opMode == MODE_PU)
        else $error("panel mode not held under setting 1");
    fixed_comb_a: assert property ((mode_select_param == MSEL_COMB_A
        || mode_select_param == MSEL_COMB_B) |=> opMode == MODE_COMB)
        else $error("combined mode not held under setting 3 or 4");
    interlock_ext_a: assert property ((mode_select_param == MSEL_INTERLOCK && !lockIn)
        |=> opMode == MODE_EXT)
        else $error("external mode not forced with interlock off");
    stop_ext_a: assert property (output_stop_input
        |-> opMode == MODE_EXT && $past(lockIn))
        else $error("output stop outside external mode");
    hold_running_a: assert property ((!switchOk && !isFixed && !initPending
        && !powerFailRestore) |=> $stable(opMode))
        else $error("mode changed while running");
    never_panel_a: assert property ((mode_select_param == MSEL_EXT_NET && netExtActive
        && switchOk && !initPending && !powerFailRestore) |=> opMode != MODE_PU)
        else $error("panel mode entered under setting 2");
    legal_msel_a: assert property (fnLegalMsel(mode_select_param))
        else $error("illegal mode select value");
    netext_on_a: assert property ((netExtActive && neIn && !netUnusable && switchOk
        && !isFixed && !initPending && !powerFailRestore) |=> opMode == MODE_NET)
        else $error("network mode not entered on net/ext switch");
    restore_a: assert property ((powerFailRestore && restoreHeld && !isFixed
        && !initPending) |=> $stable(opMode))
        else $error("mode not restored after power failure");

    switch_run_c: cover property (motorRunning && startCmd && switchValid
        && mode_select_param == MSEL_SWITCHOVR ##1 $changed(opMode));
    key_toggle_c: cover property (panelKeyToggle && smodeHigh ##1 $changed(opMode));
    stop_c: cover property ($rose(output_stop_input));

endmodule

// ---- rtl/oms_pkg.sv ----
// Constants and types shared by the operation-mode selector
package oms_pkg;

    // ----------------------------------------
    // Operation modes
    // ----------------------------------------
    typedef enum logic [1:0] {MODE_EXT, MODE_PU, MODE_NET, MODE_COMB} oms_mode_t;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_MODE_SELECT  = 8'h00;
    localparam logic [7:0] OFS_STARTUP_MODE = 8'h04;
    localparam logic [7:0] OFS_NET_CMD_SRC  = 8'h08;
    localparam logic [7:0] OFS_WRITE_PROT   = 8'h0c;
    localparam logic [7:0] OFS_STATUS       = 8'h10;
    localparam logic [7:0] OFS_TERM_FN_BASE = 8'h20;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_MODE_SELECT  = 8'h00;
    localparam logic [7:0] RST_STARTUP_MODE = 8'h00;
    localparam logic [7:0] RST_NET_CMD_SRC  = 8'h00;
    localparam logic [7:0] RST_WRITE_PROT   = 8'h00;
    localparam logic [7:0] RST_TERM_FN      = 8'h00;

    // ----------------------------------------
    // Setting values and terminal function codes
    // ----------------------------------------
    localparam logic [7:0] MSEL_PU_FIXED  = 8'h01;
    localparam logic [7:0] MSEL_EXT_NET   = 8'h02;
    localparam logic [7:0] MSEL_COMB_A    = 8'h03;
    localparam logic [7:0] MSEL_COMB_B    = 8'h04;
    localparam logic [7:0] MSEL_SWITCHOVR = 8'h06;
    localparam logic [7:0] MSEL_INTERLOCK = 8'h07;
    localparam logic [7:0] SMODE_NET      = 8'h01;
    localparam logic [7:0] SMODE_NET_RST  = 8'h02;
    localparam logic [7:0] SMODE_PUNET    = 8'h0a;
    localparam logic [7:0] SMODE_PUNET_RST = 8'h0c;
    localparam logic [7:0] FN_NETPANEL    = 8'h41;
    localparam logic [7:0] FN_NETEXT      = 8'h42;
    localparam logic [7:0] FN_PANELEXT    = 8'h10;
    localparam logic [7:0] WPROT_DISABLED = 8'h01;
    localparam logic [1:0] SYNC_STAGES    = 2'h2;

endpackage

// ---- rtl/oms_sync.sv ----
// Two-flop synchroniser for the assignable terminal inputs
module oms_sync
    import oms_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            stage1  <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule

// ---- dv/oms_terminal_model.sv ----
// Terminal panel model driving the four assignable switch pins
module oms_terminal_model
(
    input  wire logic       clk,
    input  wire logic [3:0] pinReq,
    output logic            netpanel_switch_input,
    output logic            netext_switch_input,
    output logic            panel_interlock_input,
    output logic            panel_ext_switch_input
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Pins move just after an edge, like a real contact bank seen by a sync stage
    // ----------------------------------------
    initial
    begin
        {panel_ext_switch_input, panel_interlock_input} = 2'h0;
        {netext_switch_input, netpanel_switch_input}    = 2'h0;
    end

    always @(posedge clk)
    begin
        netpanel_switch_input  <= pinReq[0];
        netext_switch_input    <= pinReq[1];
        panel_interlock_input  <= pinReq[2];
        panel_ext_switch_input <= pinReq[3];
    end
endmodule

// ---- dv/operation_mode_selector_bench.sv ----
// Self-checking bench for the operation-mode selector
module operation_mode_selector_bench;
    import oms_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_b, wr, rd, run, start, optFit, keyTgl, pfRestore;
    logic [7:0] addr, wdata, rdata, prevMsel;
    logic [3:0] pinReq;
    logic       npSw, neSw, ilk, peSw, outStop;
    oms_mode_t  opMode;
    int         miscompares, tests_run, seed, i;

    // ----------------------------------------
    // Design and terminal model
    // ----------------------------------------
    oms_mode_selector u_oms_mode_selector (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .netpanel_switch_input(npSw),
        .netext_switch_input(neSw), .panel_interlock_input(ilk),
        .panel_ext_switch_input(peSw), .motorRunning(run), .startCmd(start),
        .commOptionFitted(optFit), .panelKeyToggle(keyTgl),
        .powerFailRestore(pfRestore), .opMode(opMode), .output_stop_input(outStop));
    oms_terminal_model u_oms_terminal_model (.clk(clk), .pinReq(pinReq),
        .netpanel_switch_input(npSw), .netext_switch_input(neSw),
        .panel_interlock_input(ilk), .panel_ext_switch_input(peSw));

    // ----------------------------------------
    // Tasks and expectation functions
    // ----------------------------------------
    function automatic logic mselOk(input logic [7:0] v);
        return (v <= 8'h04) || (v == 8'h06) || (v == 8'h07);
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    // Pin change needs the model's pin flop, two sync stages plus the mode register; six edges is ample
    task automatic modeAfter(input logic [3:0] p, input oms_mode_t m);
        @(posedge clk);
        pinReq <= p;
        repeat (6) @(posedge clk);
        #1 chk({6'h0, opMode}, {6'h0, m});
    endtask

    // One-cycle pulse on the panel key or on the power-failure recovery input
    task automatic pulseChk(input logic key, input oms_mode_t m);
        @(posedge clk);
        keyTgl <= key;
        pfRestore <= !key;
        @(posedge clk);
        keyTgl <= 1'b0;
        pfRestore <= 1'b0;
        #1 chk({6'h0, opMode}, {6'h0, m});
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        #200000;
        miscompares++;
        test_done();
    end

    initial
    begin
        {rst_b, wr, rd, run, start, keyTgl, pfRestore} = 7'h0;
        optFit = 1'b1; addr = 8'h00; wdata = 8'h00; pinReq = 4'h0; seed = 32'ha860;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rdChk(OFS_MODE_SELECT, RST_MODE_SELECT);
        rdChk(OFS_STARTUP_MODE, RST_STARTUP_MODE);
        chk({6'h0, opMode}, {6'h0, MODE_EXT});
        rdChk(8'hfc, 8'h00);
        prevMsel = 8'h00;
        for (i = 0; i < 9; i++)
        begin
            wrReg(OFS_MODE_SELECT, i[7:0]);
            if (mselOk(i[7:0]))
                prevMsel = i[7:0];
            rdChk(OFS_MODE_SELECT, prevMsel);
        end
        wrReg(OFS_MODE_SELECT, 8'h00);
        wrReg(OFS_TERM_FN_BASE, FN_NETEXT);
        modeAfter(4'h2, MODE_NET);
        modeAfter(4'h0, MODE_EXT);
        wrReg(OFS_STARTUP_MODE, SMODE_NET_RST);
        modeAfter(4'h2, MODE_NET);
        @(posedge clk);
        pfRestore <= 1'b1;
        @(posedge clk);
        pfRestore <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({6'h0, opMode}, {6'h0, MODE_NET});
        // Running: a switch change must not disturb the mode outside switch-over
        run <= 1'b1; start <= 1'b1;
        modeAfter(4'h0, MODE_NET);
        run <= 1'b0; start <= 1'b0;
        modeAfter(4'h0, MODE_EXT);
        wrReg(OFS_MODE_SELECT, MSEL_SWITCHOVR);
        run <= 1'b1; start <= 1'b1;
        modeAfter(4'h2, MODE_NET);
        run <= 1'b0; start <= 1'b0;
        wrReg(OFS_MODE_SELECT, MSEL_EXT_NET);
        modeAfter(4'h0, MODE_EXT);
        wrReg(OFS_MODE_SELECT, 8'h00);
        optFit <= 1'b0;
        modeAfter(4'h2, MODE_PU);
        optFit <= 1'b1;
        wrReg(OFS_MODE_SELECT, MSEL_INTERLOCK);
        modeAfter(4'h2, MODE_EXT);
        modeAfter(4'h4, MODE_EXT);
        chk({7'h0, outStop}, 8'h01);
        rdChk(OFS_STATUS, 8'h18);
        modeAfter(4'h6, MODE_NET);
        chk({7'h0, outStop}, 8'h00);
        wrReg(OFS_MODE_SELECT, 8'h00);
        wrReg(OFS_STARTUP_MODE, SMODE_PUNET);
        wrReg(OFS_TERM_FN_BASE, FN_NETPANEL);
        modeAfter(4'h1, MODE_PU);
        modeAfter(4'h0, MODE_NET);
        modeAfter(4'h3, MODE_NET);
        wrReg(OFS_TERM_FN_BASE + 8'h04, FN_PANELEXT);
        modeAfter(4'h8, MODE_EXT);
        modeAfter(4'h0, MODE_PU);
        // No switch assigned, so only the panel key and recovery move the mode
        wrReg(OFS_TERM_FN_BASE, RST_TERM_FN);
        wrReg(OFS_TERM_FN_BASE + 8'h04, RST_TERM_FN);
        pulseChk(1'b0, MODE_NET);
        pulseChk(1'b1, MODE_PU);
        wrReg(OFS_STARTUP_MODE, SMODE_PUNET_RST);
        pulseChk(1'b0, MODE_PU);
        // Startup setting while running: only with a communication option
        run <= 1'b1;
        start <= 1'b1;
        wrReg(OFS_STARTUP_MODE, SMODE_NET);
        rdChk(OFS_STARTUP_MODE, SMODE_NET);
        optFit <= 1'b0;
        wrReg(OFS_STARTUP_MODE, SMODE_PUNET);
        rdChk(OFS_STARTUP_MODE, SMODE_NET);
        optFit <= 1'b1;
        run <= 1'b0;
        start <= 1'b0;
        wrReg(OFS_WRITE_PROT, WPROT_DISABLED);
        wrReg(OFS_MODE_SELECT, MSEL_SWITCHOVR);
        rdChk(OFS_MODE_SELECT, MSEL_SWITCHOVR);
        wrReg(OFS_NET_CMD_SRC, 8'h05);
        rdChk(OFS_NET_CMD_SRC, RST_NET_CMD_SRC);
        // Fixed settings under random pin traffic
        for (i = 0; i < 12; i++)
        begin
            wrReg(OFS_MODE_SELECT, (i % 3 == 0) ? MSEL_PU_FIXED :
                  (i % 3 == 1) ? MSEL_COMB_A : MSEL_COMB_B);
            modeAfter(4'($random(seed)), (i % 3 == 0) ? MODE_PU : MODE_COMB);
        end
        test_done();
    end
endmodule
